// *** hdl/mcap_port.sv ***
/*
  Transmit side of the multichannel audio serial port with its AHB-Lite
  register slave, I2S and left-justified framing, slot mapping, shared-bus
  options, master clock generation and clock checking.
  Assumes bus and pin inputs synchronous to hclk; the bit clock is slow
  enough that every level is seen for at least one hclk cycle.
*/
// Implementation choices: the AHB-Lite interface to the registers and the register offsets.
module mcap_port (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        bit_clock_in,
  output logic             bit_clock_out,
  output logic             bit_clock_oe,
  input  wire logic        frame_sync_in,
  output logic             frame_sync_out,
  output logic             frame_sync_oe,
  output logic             sdout,
  output logic             sdout_oe,
  output logic             general_output_pin,
  output logic             general_output_oe,
  input  wire logic        general_input_pin,
  output logic             record_mute,
  output logic      [11:0] clk_ratio
);
  mcap_pkg::mcap_cfg_t  cfg_q;
  mcap_pkg::mcap_chen_t chen_q;
  mcap_pkg::mcap_mclk_t mclk_q;
  mcap_pkg::mcap_lane_t [1:0] cur;
  mcap_pkg::mcap_lane_t [1:0] dly_q;
  mcap_pkg::mcap_lane_t [1:0] sd_q;
  logic [31:0]            slotlo_q;
  logic [31:0]            slothi_q;
  logic [63:0]            slots;
  logic [31:0]            smp_q [mcap_pkg::NCH];
  logic [31:0]            rdata_d;
  logic [7:0]             addr_q;
  logic                   wr_q;
  logic                   err_q;
  logic                   rate_err;
  logic [15:0]            period;
  logic                   gen_bclk;
  logic                   gen_fs;
  logic                   bclk_s;
  logic                   fs_s;
  logic                   bclk_prev_q;
  logic                   fs_prev_q;
  logic                   fall;
  logic                   fs_edge;
  logic                   is_i2s;
  logic                   is_lj;
  logic                   right;
  logic [10:0]            start_w;
  logic [10:0]            cnt_q;
  logic [10:0]            cnt_d;
  logic                   run_q;
  logic                   run_d;
  logic [4:0]             bit_q;
  logic [4:0]             bit_d;
  logic [4:0]             slot_q;
  logic [4:0]             slot_d;
  logic [4:0]             last;
  logic                   has;
  logic [4:0]             wl_m1;
  logic                   bclk_pin_q;
  logic                   bclk_oe_q;
  logic                   fs_pin_q;
  logic                   fs_oe_q;
  logic                   acc;

  // Lane driver: owned slot, then daisy data, then holder, then float or low.
  function automatic mcap_pkg::mcap_lane_t drive(input mcap_pkg::mcap_lane_t c,
                                                 input mcap_pkg::mcap_lane_t prev,
                                                 input logic dz,
                                                 input logic dz_bit,
                                                 input mcap_pkg::mcap_cfg_t k,
                                                 input logic mute);
    drive    = c;
    drive.oe = 1'b1;
    if (c.own)
      drive.data = c.data & ~mute;
    else if (dz)
      drive.data = dz_bit;
    else if (k.bus_hold)
      drive.data = prev.data;
    else if (k.tristate)
    begin
      drive.oe   = 1'b0;
      drive.data = prev.data;
    end
    else
      drive.data = 1'b0;
  endfunction : drive

  assign acc   = hsel && hready && htrans[1];
  assign slots = {slothi_q, slotlo_q};

  // Address phase capture; zero wait states; hreadyout is low in reset and high from the first clock after it.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q      <= 1'b0;
      addr_q    <= 8'h00;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp     <= 1'b0;
    end
    else
    begin
      wr_q      <= acc && hwrite;
      addr_q    <= acc ? haddr[7:0] : addr_q;
      hrdata    <= (acc && !hwrite) ? rdata_d : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read mux; unmapped words read as zero.
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    if (haddr[7:5] == mcap_pkg::A_SAMPLE[7:5])
      rdata_d = smp_q[haddr[4:2]];
    else
      unique case (haddr[7:0])
        mcap_pkg::A_CTRL:   rdata_d = cfg_q;
        mcap_pkg::A_SLOTLO: rdata_d = slotlo_q;
        mcap_pkg::A_SLOTHI: rdata_d = slothi_q;
        mcap_pkg::A_CHEN:   rdata_d = chen_q;
        mcap_pkg::A_MCLK:   rdata_d = mclk_q;
        mcap_pkg::A_STAT:   rdata_d = {period, clk_ratio, 3'h0, err_q};
        default:            rdata_d = 32'h0000_0000;
      endcase
  end

  // Control registers written in the data phase.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      cfg_q    <= mcap_pkg::CTRL_RST;
      slotlo_q <= 32'h0000_0000;
      slothi_q <= 32'h0000_0000;
      chen_q   <= 32'h0000_0000;
      mclk_q   <= mcap_pkg::MCLK_RST;
    end
    else if (wr_q)
    begin
      unique case (addr_q)
        mcap_pkg::A_CTRL:   cfg_q    <= hwdata;
        mcap_pkg::A_SLOTLO: slotlo_q <= hwdata;
        mcap_pkg::A_SLOTHI: slothi_q <= hwdata;
        mcap_pkg::A_CHEN:   chen_q   <= hwdata;
        mcap_pkg::A_MCLK:   mclk_q   <= hwdata;
        default:            ;
      endcase
    end
  end

  // Sample words, left aligned; shorter words use the top bits.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      for (int c = 0; c < mcap_pkg::NCH; c++)
        smp_q[c] <= 32'h0000_0000;
    end
    else if (wr_q && addr_q[7:5] == mcap_pkg::A_SAMPLE[7:5])
      smp_q[addr_q[4:2]] <= hwdata;
  end

  // sticky clock error
  // A new error wins over a write-one-to-clear in the same cycle.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      err_q <= 1'b0;
    else if (rate_err)
      err_q <= 1'b1;
    else if (wr_q && addr_q == mcap_pkg::A_STAT && hwdata[0])
      err_q <= 1'b0;
  end

  mcap_rate_det u_rate (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .fall     (fall),
    .fs_rise  (fs_edge && fs_s),
    .ratio_q  (clk_ratio),
    .period_q (period),
    .err_q    (rate_err)
  );
  assign record_mute = rate_err;

  mcap_clk_gen u_gen (
    .hclk     (hclk),
    .hresetn  (hresetn),
    .en       (cfg_q.master),
    .mcfg     (mclk_q),
    .fs_first (is_lj),
    .bclk_q   (gen_bclk),
    .fs_q     (gen_fs)
  );

  assign is_i2s  = cfg_q.serial_framing_select == mcap_pkg::FR_I2S;
  assign is_lj   = cfg_q.serial_framing_select == mcap_pkg::FR_LJ;
  assign bclk_s  = cfg_q.master ? gen_bclk : (bit_clock_in ^ cfg_q.bit_clock_polarity);
  assign fs_s    = cfg_q.master ? gen_fs : frame_sync_in;
  assign fall    = bclk_prev_q && !bclk_s;
  assign fs_edge = fall && (fs_s != fs_prev_q);
  assign right   = is_i2s ? fs_s : !fs_s;
  assign start_w = 11'(is_i2s) + 11'(cfg_q.slot_delay);
  assign wl_m1   = 5'(mcap_pkg::wlen_bits(cfg_q.serial_word_length) - 6'h01);
  assign cnt_d   = fs_edge ? 11'h000 : (cnt_q == mcap_pkg::CNT_MAX ? cnt_q : cnt_q + 11'h001);

  // Edge tracking and half-frame position, advanced once per bit-clock fall.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bclk_prev_q <= 1'b0;
      fs_prev_q   <= 1'b0;
      cnt_q       <= mcap_pkg::CNT_MAX;
      run_q       <= 1'b0;
      bit_q       <= 5'h00;
      slot_q      <= 5'h00;
    end
    else
    begin
      bclk_prev_q <= bclk_s;
      fs_prev_q   <= fall ? fs_s : fs_prev_q;
      cnt_q       <= fall ? cnt_d : cnt_q;
      run_q       <= run_d;
      bit_q       <= bit_d;
      slot_q      <= slot_d;
    end
  end

  // Highest slot used in the current half.
  always_comb
  begin
    has  = 1'b0;
    last = 5'h00;
    for (int c = 0; c < mcap_pkg::NCH; c++)
      if (chen_q.en[c] && slots[c*mcap_pkg::SLOT_ST+5] == right)
      begin
        if (!has || slots[c*mcap_pkg::SLOT_ST +: 5] > last)
          last = slots[c*mcap_pkg::SLOT_ST +: 5];
        has = 1'b1;
      end
  end

  // Slot sequencer: start at the delayed half start, walk bits, stop after last.
  always_comb
  begin
    run_d  = run_q;
    bit_d  = bit_q;
    slot_d = slot_q;
    if (fall)
    begin
      if (cnt_d == start_w && has && (is_i2s || is_lj))
      begin
        run_d  = 1'b1;
        bit_d  = 5'h00;
        slot_d = 5'h00;
      end
      else if (fs_edge)
        run_d = 1'b0;
      else if (run_q && bit_q == wl_m1)
      begin
        bit_d = 5'h00;
        if (slot_q == last)
          run_d = 1'b0;
        else
          slot_d = slot_q + 5'h01;
      end
      else if (run_q)
        bit_d = bit_q + 5'h01;
    end
  end

  always_comb
  begin
    int l;
    l   = 0;
    cur = '0;
    for (int c = 0; c < mcap_pkg::NCH; c++)
    begin
      l = (cfg_q.lane2_en && chen_q.lane2[c]) ? 1 : 0;
      if (run_d && chen_q.en[c] && slots[c*mcap_pkg::SLOT_ST +: 6] == {right, slot_d})
      begin
        cur[l].own  = 1'b1;
        cur[l].data = smp_q[c][mcap_pkg::MSB_IDX - bit_d];
      end
    end
  end

  // Both data lanes update only at a bit-clock fall.
  for (genvar g = 0; g < 2; g++)
  begin : g_lane
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
      begin
        dly_q[g] <= '0;
        sd_q[g]  <= '0;
      end
      else if (fall)
      begin
        dly_q[g] <= cur[g];
        if (g == 1 && !cfg_q.lane2_en)
          sd_q[g] <= '0;
        else
          sd_q[g] <= drive(cfg_q.late_latch ? dly_q[g] : cur[g], sd_q[g],
                           g == 0 && cfg_q.daisy_en, general_input_pin, cfg_q, rate_err);
      end
    end
  end
  assign sdout              = sd_q[0].data;
  assign sdout_oe           = sd_q[0].oe;
  assign general_output_pin = sd_q[1].data;
  assign general_output_oe  = sd_q[1].oe;

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bclk_pin_q <= 1'b0;
      bclk_oe_q  <= 1'b0;
      fs_pin_q   <= 1'b0;
      fs_oe_q    <= 1'b0;
    end
    else
    begin
      bclk_pin_q <= gen_bclk ^ cfg_q.bit_clock_polarity;
      bclk_oe_q  <= cfg_q.master;
      fs_pin_q   <= gen_fs;
      fs_oe_q    <= cfg_q.master;
    end
  end
  assign bit_clock_out  = bclk_pin_q;
  assign bit_clock_oe   = bclk_oe_q;
  assign frame_sync_out = fs_pin_q;
  assign frame_sync_oe  = fs_oe_q;

  sequence s_start;
    $rose(run_q);
  endsequence

  a_i2s_data_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    is_i2s && $changed(sdout) |-> $past(fall))
    else $error("I2S data moved off a fall");
  a_lj_data_fall: assert property (@(posedge hclk) disable iff (!hresetn)
    is_lj && $changed(sdout) |-> $past(fall))
    else $error("left-justified data moved off a fall");
  a_i2s_left_msb: assert property (@(posedge hclk) disable iff (!hresetn)
    s_start and is_i2s and !fs_prev_q |-> cnt_q == 11'(cfg_q.slot_delay) + 11'h001 && slot_q == 5'h00 && bit_q == 5'h00)
    else $error("I2S left start misplaced");
  a_i2s_right_msb: assert property (@(posedge hclk) disable iff (!hresetn)
    s_start and is_i2s and fs_prev_q |-> cnt_q == 11'(cfg_q.slot_delay) + 11'h001)
    else $error("I2S right start misplaced");
  a_lj_left_msb: assert property (@(posedge hclk) disable iff (!hresetn)
    s_start and is_lj and fs_prev_q |-> cnt_q == 11'(cfg_q.slot_delay))
    else $error("left-justified left start misplaced");
  a_lj_right_msb: assert property (@(posedge hclk) disable iff (!hresetn)
    s_start and is_lj and !fs_prev_q |-> cnt_q == 11'(cfg_q.slot_delay))
    else $error("left-justified right start misplaced");
  a_idle_after_last: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(fall) && !cfg_q.late_latch && $stable(cfg_q) && sd_q[0].own |-> $past(run_d))
    else $error("slot data after the last slot");
  a_tristate_free: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(fall && cfg_q.tristate && !cfg_q.bus_hold && !cfg_q.daisy_en) && !sd_q[0].own |-> !sdout_oe)
    else $error("unowned slot driven while floating enabled");
  a_bus_holder: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(fall && cfg_q.bus_hold && !cfg_q.daisy_en) && !sd_q[0].own |-> sdout_oe && $stable(sdout))
    else $error("bus holder lost the level");
  a_mute_err: assert property (@(posedge hclk) disable iff (!hresetn)
    $past(fall && rate_err) && sd_q[0].own |-> !sdout ##1 err_q)
    else $error("muted channel sent data");
endmodule : mcap_port

// *** hdl/mcap_pkg.sv ***
/*
  Shared definitions of the multichannel audio port: register map, layouts,
  reset values, framing codes and clock-check limits.
  Assumes a 10 MHz hclk and a 32-bit AHB-Lite register bus.
*/
package mcap_pkg;

  // Register byte offsets.
  localparam logic [7:0] A_CTRL   = 8'h00;
  localparam logic [7:0] A_SLOTLO = 8'h04;
  localparam logic [7:0] A_SLOTHI = 8'h08;
  localparam logic [7:0] A_CHEN   = 8'h0C;
  localparam logic [7:0] A_STAT   = 8'h10;
  localparam logic [7:0] A_MCLK   = 8'h14;
  localparam logic [7:0] A_SAMPLE = 8'h20;

  // Reset values: 32-bit words, framing code 00, master ratio 64, half period 4.
  localparam logic [31:0] CTRL_RST = 32'h0000_000C;
  localparam logic [31:0] MCLK_RST = 32'h0000_4004;

  // Sizes and fixed indices.
  localparam int              NCH     = 8;
  localparam int              SLOT_ST = 8;
  localparam int              CNT_W   = 11;
  localparam logic [10:0]     CNT_MAX = 11'h7FF;
  localparam logic [4:0]      MSB_IDX = 5'h1F;

  // Clock-check limits, all in kHz.
  localparam int unsigned CLK_KHZ     = 10000;
  localparam int unsigned FS_MIN_KHZ  = 8;
  localparam int unsigned FS_MAX_KHZ  = 768;
  localparam int unsigned BCK_MIN_KHZ = 256;
  localparam int unsigned BCK_MAX_KHZ = 24576;

  typedef enum logic [1:0] {FR_TDM = 2'b00, FR_I2S = 2'b01, FR_LJ = 2'b10, FR_RSV = 2'b11} mcap_frame_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [4:0]  slot_delay;
    logic        late_latch;
    logic        daisy_en;
    logic        lane2_en;
    logic        bus_hold;
    logic        tristate;
    logic        master;
    logic        bit_clock_polarity;
    logic [1:0]  serial_word_length;
    mcap_frame_t serial_framing_select;
  } mcap_cfg_t;

  typedef struct packed {
    logic [15:0] rsvd;
    logic [7:0]  lane2;
    logic [7:0]  en;
  } mcap_chen_t;

  typedef struct packed {
    logic [11:0] rsvd;
    logic [11:0] ratio;
    logic [7:0]  half;
  } mcap_mclk_t;

  typedef struct packed {
    logic [15:0] period;
    logic [11:0] ratio;
    logic [2:0]  rsvd;
    logic        err;
  } mcap_stat_t;

  typedef struct packed {
    logic own;
    logic oe;
    logic data;
  } mcap_lane_t;

  // Word length code to bits per slot.
  function automatic logic [5:0] wlen_bits(input logic [1:0] c);
    unique case (c)
      2'b00: wlen_bits = 6'h10;
      2'b01: wlen_bits = 6'h14;
      2'b10: wlen_bits = 6'h18;
      2'b11: wlen_bits = 6'h20;
    endcase
  endfunction : wlen_bits

  // True for a bit-clock to frame-sync ratio that auto-configuration knows.
  function automatic logic std_ratio(input logic [11:0] r);
    std_ratio = r inside {12'h010, 12'h018, 12'h020, 12'h030, 12'h040, 12'h060, 12'h080,
                          12'h0C0, 12'h100, 12'h180, 12'h200, 12'h400, 12'h800};
  endfunction : std_ratio

endpackage : mcap_pkg

// *** hdl/mcap_clk_gen.sv ***
/*
  Bit-clock and frame-sync generator for bus-master operation.
  Assumes half >= 1 and an even ratio; a zero half period acts as one.
*/
module mcap_clk_gen (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               en,
  input  wire mcap_pkg::mcap_mclk_t mcfg,
  input  wire logic               fs_first,
  output logic                    bclk_q,
  output logic                    fs_q
);
  logic [7:0]  div_q;
  logic [11:0] cnt_q;
  logic [11:0] cnt_d;
  logic        wrap;

  assign wrap  = (mcfg.half == 8'h00) || (div_q >= mcfg.half - 8'h01);
  assign cnt_d = (cnt_q >= mcfg.ratio - 12'h001) ? 12'h000 : cnt_q + 12'h001;

  // Frame sync only moves as the bit clock falls, like the data.
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      div_q  <= 8'h00;
      cnt_q  <= 12'h000;
      bclk_q <= 1'b0;
      fs_q   <= 1'b0;
    end
    else if (!en)
    begin
      div_q  <= 8'h00;
      cnt_q  <= 12'h000;
      bclk_q <= 1'b0;
      fs_q   <= fs_first;
    end
    else if (wrap)
    begin
      div_q  <= 8'h00;
      bclk_q <= ~bclk_q;
      if (bclk_q)
      begin
        cnt_q <= cnt_d;
        fs_q  <= (cnt_d < (mcfg.ratio >> 1)) ? fs_first : ~fs_first;
      end
    end
    else
    begin
      div_q <= div_q + 8'h01;
    end
  end
endmodule : mcap_clk_gen

// *** hdl/mcap_rate_det.sv ***
/*
  Frame-rate and ratio detector: counts hclk cycles and bit-clock falls
  between frame-sync rises and flags combinations that are not supported.
  Assumes one-cycle pulses for each bit-clock fall and frame-sync rise.
*/
module mcap_rate_det (
  input  wire logic  hclk,
  input  wire logic  hresetn,
  input  wire logic  fall,
  input  wire logic  fs_rise,
  output logic [11:0] ratio_q,
  output logic [15:0] period_q,
  output logic        err_q
);
  logic [11:0] bcnt_q;
  logic [15:0] pcnt_q;
  logic        seen_q;
  logic        bad;
  int unsigned r_k;
  int unsigned p_k;

  assign r_k = int'(bcnt_q);
  assign p_k = int'(pcnt_q);
  assign bad = !mcap_pkg::std_ratio(bcnt_q)
             || (p_k * mcap_pkg::FS_MIN_KHZ > mcap_pkg::CLK_KHZ)
             || (p_k * mcap_pkg::FS_MAX_KHZ < mcap_pkg::CLK_KHZ)
             || (r_k * mcap_pkg::CLK_KHZ < p_k * mcap_pkg::BCK_MIN_KHZ)
             || (r_k * mcap_pkg::CLK_KHZ > p_k * mcap_pkg::BCK_MAX_KHZ);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      bcnt_q   <= 12'h000;
      pcnt_q   <= 16'h0000;
      seen_q   <= 1'b0;
      ratio_q  <= 12'h000;
      period_q <= 16'h0000;
      err_q    <= 1'b0;
    end
    else if (fs_rise)
    begin
      bcnt_q   <= 12'h001;
      pcnt_q   <= 16'h0001;
      seen_q   <= 1'b1;
      ratio_q  <= seen_q ? bcnt_q : ratio_q;
      period_q <= seen_q ? pcnt_q : period_q;
      err_q    <= seen_q && bad;
    end
    else
    begin
      pcnt_q <= (pcnt_q == 16'hFFFF) ? pcnt_q : pcnt_q + 16'h0001;
      if (fall && bcnt_q != 12'hFFF)
        bcnt_q <= bcnt_q + 12'h001;
    end
  end

  a_bad_ratio: assert property (@(posedge hclk) disable iff (!hresetn)
    fs_rise && seen_q && !mcap_pkg::std_ratio(bcnt_q) |=> err_q && ratio_q == $past(bcnt_q))
    else $error("unsupported ratio not flagged");
  a_slow_bclk: assert property (@(posedge hclk) disable iff (!hresetn)
    fs_rise && seen_q && (r_k * mcap_pkg::CLK_KHZ < p_k * mcap_pkg::BCK_MIN_KHZ) |=> err_q)
    else $error("slow bit clock not flagged");
endmodule : mcap_rate_det

// *** tb/mcap_host.sv ***
/*
  Host model: a free-running bit clock and frame sync for the port.
  Assumes a 10 MHz hclk; 16 hclk per bit, 64 bits per frame.
*/
module mcap_host (
  input  wire logic hclk,
  input  wire logic hresetn,
  output logic      bck,
  output logic      fs
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [9:0] t_q;
  // Frame sync toggles only where the bit clock falls.
  // 32 bits per half
  always_ff @(posedge hclk or negedge hresetn)
    if (!hresetn)
      t_q <= 10'h000;
    else
      t_q <= t_q + 10'h001;
  assign bck = t_q[3];
  assign fs  = t_q[9];
endmodule : mcap_host

// *** tb/test_multichannel_i2s_lj_audio_port.sv ***
/*
  Self-checking bench: AHB-Lite master, host model and a bit-level model.
  Assumes the port drives its lane a few hclk after each bit-clock fall.
*/
module test_multichannel_i2s_lj_audio_port;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, bck, fs, fs_p, armed, left;
  logic        hreadyout, sdout, sdout_oe, record_mute, hresp, bco, fso, gpo_oe, gpi, ll;
  logic [1:0]  htrans, fr;
  logic [4:0]  d;
  logic [11:0] clk_ratio;
  logic [31:0] haddr, hwdata, hrdata, r, seed, e;
  logic [31:0] smp [2];
  int          errors, samples_checked, idx, off, i;

  mcap_host host (.hclk, .hresetn, .bck, .fs);
  mcap_port dut (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hrdata, .hreadyout, .hresp, .bit_clock_in(bck), .bit_clock_out(),
    .bit_clock_oe(bco), .frame_sync_in(fs), .frame_sync_out(), .frame_sync_oe(fso), .sdout, .sdout_oe,
    .general_output_pin(), .general_output_oe(gpo_oe), .general_input_pin(gpi), .record_mute, .clk_ratio);

  function automatic logic [31:0] xs(input logic [31:0] v);
    v ^= v << 13;
    v ^= v >> 17;
    v ^= v << 5;
    return v;
  endfunction : xs

  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      errors++;
      $display("[FAIL] t=%0t got %h exp %h", $time, g, x);
    end
  endtask : chk

  task automatic wrap_up;
    $display("errors=%0d samples_checked=%0d", errors, samples_checked);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : wrap_up

  // One single AHB-Lite transfer; waits on hready, never on a fixed count.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] v, output logic [31:0] q);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= v;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask : bus

  initial
  begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end

  // Position counts bit-clock rises since frame sync last changed.
  always @(posedge bck)
  begin
    idx  = (fs !== fs_p) ? 0 : idx + 1;
    fs_p = fs;
    left = (fr == 2'b01) ? !fs : fs;
    e    = (idx >= off && idx < off + 16) ? {30'h0, 1'b1, smp[!left][31 - (idx - off)]} : {30'h0, ll, ll};
    if (armed)
      chk({30'h0, sdout_oe, sdout_oe & sdout}, e);
  end

  initial
  begin
    #5ms;
    errors++;
    wrap_up;
  end

  initial
  begin
    {hresetn, hsel, hwrite, armed, fs_p, ll} = 6'h00;
    {htrans, haddr, hwdata} = 66'h0;
    {fr, off, idx, errors, samples_checked} = '0;
    gpi <= 1'b0;
    seed = 32'h0000_0059;
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, mcap_pkg::A_CTRL, 32'h0, r);
    chk(r, mcap_pkg::CTRL_RST);
    bus(1'b0, 8'h3C, 32'h0, r);
    chk(r, 32'h0);
    // Channel 0 owns left slot 0, channel 1 right slot 0.
    bus(1'b1, mcap_pkg::A_SLOTLO, 32'h0000_2000, r);
    bus(1'b1, mcap_pkg::A_CHEN, 32'h0000_0003, r);
    // Last pass: left-justified with delay, late latch and daisy input held high.
    for (i = 0; i < 4; i++)
    begin
      armed = 1'b0;
      smp[0] = xs(seed);
      smp[1] = xs(smp[0]);
      seed = smp[1];
      bus(1'b1, mcap_pkg::A_SAMPLE, smp[0], r);
      bus(1'b1, 8'h24, smp[1], r);
      fr  = i[0] ? 2'b10 : 2'b01;
      d   = (i >= 2) ? 5'h03 : 5'h00;
      ll  = (i == 3);
      gpi <= ll;
      off = d + (fr == 2'b01) + ll;
      bus(1'b1, mcap_pkg::A_CTRL, {16'h0, d, ll, ll, 3'h1, 4'h0, fr}, r);
      repeat (2) @(negedge fs);
      armed = 1'b1;
      repeat (2) @(negedge fs);
    end
    armed = 1'b0;
    chk({20'h0, clk_ratio}, 32'h40);
    chk({31'h0, record_mute}, 32'h0);
    chk({29'h0, bco, fso, gpo_oe}, 32'h0);
    // Master mode at 40 bit clocks per frame, a ratio outside the supported list.
    bus(1'b1, mcap_pkg::A_MCLK, 32'h0000_2804, r);
    bus(1'b1, mcap_pkg::A_CTRL, 32'h0000_0021, r);
    repeat (1200) @(posedge hclk);
    chk({31'h0, record_mute}, 32'h1);
    chk({20'h0, clk_ratio}, 32'h28);
    chk({29'h0, bco, fso, hresp}, 32'h6);
    // The clear loses to the error that is still present.
    bus(1'b1, mcap_pkg::A_STAT, 32'h1, r);
    bus(1'b0, mcap_pkg::A_STAT, 32'h0, r);
    chk(r, 32'h0140_0281);
    wrap_up;
  end
endmodule : test_multichannel_i2s_lj_audio_port
